// >>> ict_pkg.sv
/*
  Shared constants of the instruction cycle timing block: decode entry layout,
  per-opcode byte and clock counts, and the sequencer states.
  Assumes the opcode space of the classic 8-bit instruction set.
*/
package ict_pkg;

  localparam int OP_W      = 8;
  localparam int PC_W      = 16;
  localparam int CYC_W     = 4;
  localparam int BYTES_W   = 2;
  localparam int NIB_W     = 4;
  localparam int MAX_CYC   = 8;
  localparam int SYS_MHZ   = 50;
  localparam int PEAK_MIPS = 50;

  // decode entry: {bytes, not-taken clocks, conditional branch}
  typedef logic [BYTES_W+CYC_W:0] ict_dec_t;
  localparam int DEC_COND_BIT = 0;
  localparam int DEC_CYC_LSB  = 1;
  localparam int DEC_BYT_LSB  = DEC_CYC_LSB + CYC_W;

  localparam ict_dec_t E11 = {2'h1, 4'h1, 1'b0};
  localparam ict_dec_t E12 = {2'h1, 4'h2, 1'b0};
  localparam ict_dec_t E13 = {2'h1, 4'h3, 1'b0};
  localparam ict_dec_t E14 = {2'h1, 4'h4, 1'b0};
  localparam ict_dec_t E15 = {2'h1, 4'h5, 1'b0};
  localparam ict_dec_t E18 = {2'h1, 4'h8, 1'b0};
  localparam ict_dec_t E22 = {2'h2, 4'h2, 1'b0};
  localparam ict_dec_t E23 = {2'h2, 4'h3, 1'b0};
  localparam ict_dec_t E33 = {2'h3, 4'h3, 1'b0};
  localparam ict_dec_t E34 = {2'h3, 4'h4, 1'b0};
  localparam ict_dec_t B22 = {2'h2, 4'h2, 1'b1};
  localparam ict_dec_t B33 = {2'h3, 4'h3, 1'b1};
  localparam ict_dec_t B34 = {2'h3, 4'h4, 1'b1};

  // tables indexed by the high opcode nibble, one per low-nibble column class except column 1, which decodes to E23
  localparam ict_dec_t TAB_L0 [16] = '{E11, B33, B33, B33, B22, B22, B22, B22,
                                       E23, E33, E22, E22, E22, E22, E13, E13};
  localparam ict_dec_t TAB_L2 [16] = '{E34, E34, E15, E15, E22, E22, E22, E22,
                                       E22, E22, E22, E22, E22, E22, E13, E13};
  localparam ict_dec_t TAB_L3 [16] = '{E11, E11, E11, E11, E33, E33, E33, E13,
                                       E13, E13, E11, E11, E11, E11, E13, E13};
  localparam ict_dec_t TAB_L4 [16] = '{E11, E11, E22, E22, E22, E22, E22, E22,
                                       E18, E22, E14, B33, E11, E11, E11, E11};
  localparam ict_dec_t TAB_L5 [16] = '{E22, E22, E22, E22, E22, E22, E22, E33,
                                       E33, E22, E11, B33, E22, B33, E22, E22};
  localparam ict_dec_t TAB_RI [16] = '{E12, E12, E12, E12, E12, E12, E12, E22,
                                       E22, E12, E22, B34, E12, E12, E12, E12};
  localparam ict_dec_t TAB_RN [16] = '{E11, E11, E11, E11, E11, E11, E11, E22,
                                       E22, E11, E22, B33, E11, B22, E11, E11};

  localparam logic [NIB_W-1:0] COL_JMP11 = 4'h1;
  localparam logic [NIB_W-1:0] COL_L2    = 4'h2;
  localparam logic [NIB_W-1:0] COL_L3    = 4'h3;
  localparam logic [NIB_W-1:0] COL_L4    = 4'h4;
  localparam logic [NIB_W-1:0] COL_L5    = 4'h5;
  localparam logic [NIB_W-1:0] COL_L0    = 4'h0;

  localparam logic [OP_W-1:0] OP_NOP       = 8'h00;
  localparam logic [OP_W-1:0] OP_SJMP      = 8'h80;
  localparam logic [OP_W-1:0] OP_SPARE     = 8'ha5;
  localparam logic [OP_W-1:0] OP_CODE_PC   = 8'h83;
  localparam logic [OP_W-1:0] OP_CODE_DP   = 8'h93;
  localparam logic [NIB_W-1:0] HI_XD_RD    = 4'he;
  localparam logic [NIB_W-1:0] HI_XD_WR    = 4'hf;

  localparam logic [PC_W-1:0]  PC_RST  = 16'h0000;
  localparam logic [CYC_W-1:0] CYC_ONE = 4'h1;
  localparam logic [CYC_W-1:0] CYC_ZERO = 4'h0;

  typedef enum logic { ST_RUN, ST_HALT } ict_state_t;

endpackage : ict_pkg

// >>> ict_core.sv
/*
  Instruction cycle sequencer: decodes each opcode into its byte length and
  clock count, holds the issue port until the instruction has used all of its
  clocks, tracks the program counter for relative branches and breakpoints,
  and flags program flash accesses made through the data moves.
  Assumes fetch, datapath, flash controller and debug logic on the same clock;
  the datapath presents the branch condition and offset with the opcode.
*/
`timescale 1ns/1ps

module ict_core #(
  parameter int MAX_CYCLES = ict_pkg::MAX_CYC
) (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic                     op_valid,
  input  wire logic [ict_pkg::OP_W-1:0] opcode,
  input  wire logic                     cond_taken,
  input  wire logic [ict_pkg::OP_W-1:0] rel_offset,
  input  wire logic                     pc_load,
  input  wire logic [ict_pkg::PC_W-1:0] pc_load_addr,
  input  wire logic                     flash_wr_en,
  input  wire logic                     flash_erase_en,
  input  wire logic                     dbg_halt_req,
  input  wire logic                     dbg_run_req,
  input  wire logic                     dbg_step_req,
  input  wire logic                     bkpt_en,
  input  wire logic [ict_pkg::PC_W-1:0] bkpt_addr,
  output logic                          op_ready,
  output logic                          retire,
  output logic [ict_pkg::CYC_W-1:0]     inst_cycles,
  output logic [1:0]                    inst_bytes,
  output logic [ict_pkg::PC_W-1:0]      pc,
  output logic                          halted,
  output logic                          code_byte_move,
  output logic                          external_data_move,
  output logic                          flash_write,
  output logic                          flash_erase
);

  ict_pkg::ict_state_t            state_ff;
  ict_pkg::ict_state_t            nxt_state;
  logic [ict_pkg::CYC_W-1:0]      rem_ff;
  logic [ict_pkg::CYC_W-1:0]      nxt_rem;
  logic                           retire_ff;
  logic [ict_pkg::CYC_W-1:0]      cyc_ff;
  logic [1:0]                     bytes_ff;
  logic [ict_pkg::PC_W-1:0]       pc_ff;
  logic [ict_pkg::PC_W-1:0]       nxt_pc;
  logic                           code_ff;
  logic                           external_data_space_ff;
  logic                           fwr_ff;
  logic                           fer_ff;
  logic                           step_ff;

  // decode
  wire [ict_pkg::NIB_W-1:0] op_hi = opcode[7:4];
  wire [ict_pkg::NIB_W-1:0] op_lo = opcode[3:0];
  wire                      col_rn = opcode[3];
  wire                      col_ri = (op_lo[3:1] == 3'h3);
  // table lookup keeps encoding identical to the classic opcode map
  wire ict_pkg::ict_dec_t   dec =
    col_rn                      ? ict_pkg::TAB_RN[op_hi] :
    col_ri                      ? ict_pkg::TAB_RI[op_hi] :
    (op_lo == ict_pkg::COL_L5)  ? ict_pkg::TAB_L5[op_hi] :
    (op_lo == ict_pkg::COL_L4)  ? ict_pkg::TAB_L4[op_hi] :
    (op_lo == ict_pkg::COL_L3)  ? ict_pkg::TAB_L3[op_hi] :
    (op_lo == ict_pkg::COL_L2)  ? ict_pkg::TAB_L2[op_hi] :
    (op_lo == ict_pkg::COL_JMP11) ? ict_pkg::E23 :
    ict_pkg::TAB_L0[op_hi];
  // spare opcode lands on a one-byte one-clock entry with no side effects
  wire                      is_spare = (opcode == ict_pkg::OP_SPARE);
  wire                      is_cond = dec[ict_pkg::DEC_COND_BIT];
  wire [1:0]                dec_bytes = dec[ict_pkg::DEC_BYT_LSB +: ict_pkg::BYTES_W];
  wire [ict_pkg::CYC_W-1:0] dec_base = dec[ict_pkg::DEC_CYC_LSB +: ict_pkg::CYC_W];
  // not-taken is the base count; taken adds one clock
  wire                      br_taken = is_cond & cond_taken;
  wire [ict_pkg::CYC_W-1:0] dec_cyc = dec_base + {3'h0, br_taken};
  wire                      is_sjmp = (opcode == ict_pkg::OP_SJMP);

  // flash access through the moves
  wire is_code_rd = (opcode == ict_pkg::OP_CODE_PC) | (opcode == ict_pkg::OP_CODE_DP);
  wire xd_col     = (op_lo == ict_pkg::COL_L0) | (op_lo == ict_pkg::COL_L2) |
                    (op_lo == ict_pkg::COL_L3);
  wire is_xd_rd   = xd_col & (op_hi == ict_pkg::HI_XD_RD);
  wire is_xd_wr   = xd_col & (op_hi == ict_pkg::HI_XD_WR);

  // issue control: an instruction owns the sequencer for all its clocks
  wire pipe_free  = (rem_ff == ict_pkg::CYC_ZERO);
  wire bkpt_hit   = bkpt_en & (pc_ff == bkpt_addr) & pipe_free & ~step_ff;
  wire run_ok     = (state_ff == ict_pkg::ST_RUN) & ~dbg_halt_req & ~bkpt_hit;
  wire step_ok    = (state_ff == ict_pkg::ST_HALT) & step_ff;
  assign op_ready = pipe_free & (run_ok | step_ok);
  wire accept     = op_valid & op_ready;

  // relative target from the address after the branch
  wire [ict_pkg::PC_W-1:0] pc_after = pc_ff + {14'h0000, dec_bytes};
  wire [ict_pkg::PC_W-1:0] rel_tgt  = pc_after + {{8{rel_offset[7]}}, rel_offset};
  wire                     rel_jump = accept & (br_taken | is_sjmp);

  always_comb
  begin
    nxt_pc = pc_ff;
    if (pc_load)
      nxt_pc = pc_load_addr;
    else if (rel_jump)
      nxt_pc = rel_tgt;
    else if (accept)
      nxt_pc = pc_after;
  end

  // counter runs in plain clocks; one-clock ops load it with zero
  always_comb
  begin
    nxt_rem = rem_ff;
    if (accept)
      nxt_rem = dec_cyc - ict_pkg::CYC_ONE;
    else if (!pipe_free)
      nxt_rem = rem_ff - ict_pkg::CYC_ONE;
  end

  wire last_clk = accept ? (dec_cyc == ict_pkg::CYC_ONE) : (rem_ff == ict_pkg::CYC_ONE);

  // debug halting touches no user state, only this sequencer
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ict_pkg::ST_RUN:
        if (dbg_halt_req | bkpt_hit)
          nxt_state = ict_pkg::ST_HALT;
      ict_pkg::ST_HALT:
        if (dbg_run_req & ~dbg_halt_req)
          nxt_state = ict_pkg::ST_RUN;
      default:
        nxt_state = ict_pkg::ST_HALT;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_ff <= ict_pkg::ST_RUN;
      rem_ff   <= ict_pkg::CYC_ZERO;
      pc_ff    <= ict_pkg::PC_RST;
      step_ff  <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      rem_ff   <= nxt_rem;
      pc_ff    <= nxt_pc;
      // a step request stays armed until one instruction is issued
      step_ff  <= (step_ff | dbg_step_req) & ~accept;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      retire_ff <= 1'b0;
      cyc_ff    <= ict_pkg::CYC_ZERO;
      bytes_ff  <= 2'h0;
    end
    else
    begin
      retire_ff <= (accept | ~pipe_free) & last_clk;
      if (accept)
      begin
        cyc_ff   <= dec_cyc;
        bytes_ff <= is_spare ? 2'h1 : dec_bytes;
      end
    end
  end

  // flash path strobes, one clock at issue; the enables are software controls
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      code_ff  <= 1'b0;
      external_data_space_ff <= 1'b0;
      fwr_ff   <= 1'b0;
      fer_ff   <= 1'b0;
    end
    else
    begin
      code_ff  <= accept & is_code_rd;
      external_data_space_ff <= accept & (is_xd_rd | is_xd_wr);
      fwr_ff   <= accept & is_xd_wr & flash_wr_en & ~flash_erase_en;
      fer_ff   <= accept & is_xd_wr & flash_wr_en & flash_erase_en;
    end
  end

  assign retire             = retire_ff;
  assign inst_cycles        = cyc_ff;
  assign inst_bytes         = bytes_ff;
  assign pc                 = pc_ff;
  assign halted             = (state_ff == ict_pkg::ST_HALT);
  assign code_byte_move     = code_ff;
  assign external_data_move = external_data_space_ff;
  assign flash_write        = fwr_ff;
  assign flash_erase        = fer_ff;

endmodule : ict_core

// >>> ict_core_props.sv
/* ict_core_props: port assertions of the cycle sequencer.
   assumes one clock domain; bound to ict_core after the module */
`timescale 1ns/1ps
module ict_core_props (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        op_valid,
  input wire logic [7:0]  opcode,
  input wire logic        cond_taken,
  input wire logic [7:0]  rel_offset,
  input wire logic        pc_load,
  input wire logic        flash_wr_en,
  input wire logic        flash_erase_en,
  input wire logic        dbg_halt_req,
  input wire logic        op_ready,
  input wire logic        retire,
  input wire logic [3:0]  inst_cycles,
  input wire logic [1:0]  inst_bytes,
  input wire logic [15:0] pc,
  input wire logic        halted,
  input wire logic        code_byte_move,
  input wire logic        external_data_move,
  input wire logic        flash_write,
  input wire logic        flash_erase
);
  wire logic [15:0] rel_ext = {{8{rel_offset[7]}}, rel_offset};
  wire logic        wr_only = flash_wr_en && !flash_erase_en;
  wire logic        er_req  = flash_wr_en && flash_erase_en;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_acc(logic [7:0] op);
    op_valid && op_ready && opcode == op;
  endsequence
  sequence s_div_wait;
    !op_ready [*7] ##1 retire;
  endsequence
  AST_DIV_EIGHT: assert property (s_acc(8'h84) |=> s_div_wait)
    else $error("divide did not retire on its eighth clock");
  AST_CYC_MAX: assert property (inst_cycles <= 4'h8)
    else $error("instruction clock count above eight");
  AST_ONE_CLK: assert property (op_valid && op_ready ##1 inst_cycles == 4'h1 |-> retire && (op_ready || halted || dbg_halt_req))
    else $error("single clock instruction did not retire at once");
  AST_SPARE_NOP: assert property (s_acc(8'ha5) |=> inst_cycles == 4'h1 && inst_bytes == 2'h1 && !external_data_move)
    else $error("spare opcode differs from no-operation");
  AST_COND_TIME: assert property (s_acc(8'h60) |=> inst_cycles == ($past(cond_taken) ? 4'h3 : 4'h2))
    else $error("branch clock count wrong for its outcome");
  AST_REL_TARGET: assert property (s_acc(8'h80) && !pc_load |=> pc == $past(pc) + 16'h0002 + $past(rel_ext))
    else $error("relative target wrong");
  AST_FLASH_SEL: assert property (s_acc(8'hf0) |=> external_data_move && flash_write == $past(wr_only) && flash_erase == $past(er_req))
    else $error("flash strobe selection wrong");
  AST_CODE_READ: assert property (s_acc(8'h93) |=> code_byte_move && inst_cycles == 4'h3 && inst_bytes == 2'h1)
    else $error("code byte move decode wrong");
  AST_MOVE_DD: assert property (s_acc(8'h85) |=> inst_cycles == 4'h3 && inst_bytes == 2'h3)
    else $error("direct to direct move timing wrong");
  AST_HALT_BLOCK: assert property (dbg_halt_req |-> !op_ready ##1 halted)
    else $error("halt request did not stop issue");
endmodule : ict_core_props
bind ict_core ict_core_props u_ict_core_props (.clk(clk), .nrst(nrst), .op_valid(op_valid),
  .opcode(opcode), .cond_taken(cond_taken), .rel_offset(rel_offset), .pc_load(pc_load),
  .flash_wr_en(flash_wr_en), .flash_erase_en(flash_erase_en), .dbg_halt_req(dbg_halt_req),
  .op_ready(op_ready), .retire(retire), .inst_cycles(inst_cycles), .inst_bytes(inst_bytes),
  .pc(pc), .halted(halted), .code_byte_move(code_byte_move), .flash_write(flash_write),
  .external_data_move(external_data_move), .flash_erase(flash_erase));

// >>> ict_fetch_model.sv
/* ict_fetch_model: program memory side of the issue port, one opcode at a time.
   assumes offer is called at a rising edge */
`timescale 1ns/1ps
module ict_fetch_model (
  input  wire logic  clk,
  input  wire logic  op_ready,
  output logic       op_valid,
  output logic [7:0] opcode,
  output logic       cond_taken,
  output logic [7:0] rel_offset,
  output logic       stuck
);
  initial
  begin
    op_valid = 1'b0;
    opcode = 8'h00;
    cond_taken = 1'b0;
    rel_offset = 8'h00;
    stuck = 1'b0;
  end
  // ready is looked at mid-cycle so the next edge is the accepting one
  task automatic offer(input logic [7:0] op, input logic c, input logic [7:0] r);
    int n;
    op_valid <= 1'b1;
    opcode <= op;
    cond_taken <= c;
    rel_offset <= r;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (!op_ready && n < 60);
    if (!op_ready)
      stuck <= 1'b1;
    @(posedge clk);
  endtask : offer
  // released opcode and offset lines show the inverse so stale data cannot pass for fresh; cond_taken keeps its value
  task automatic idle();
    op_valid <= 1'b0;
    opcode <= ~opcode;
    rel_offset <= ~rel_offset;
  endtask : idle
endmodule : ict_fetch_model

// >>> ict_core_bench.sv
/* ict_core_bench: self-checking run of the cycle sequencer with a fetch model.
   assumes ict_pkg, the checker and the fetch model are compiled first */
`timescale 1ns/1ps
module ict_core_bench;
  logic        clk, nrst, flash_wr_en, flash_erase_en, dbg_halt_req, dbg_run_req;
  logic        dbg_step_req, op_valid, cond_taken, op_ready, retire, halted, stuck;
  logic        bkpt_en;
  logic [7:0]  opcode, rel_offset;
  logic [3:0]  inst_cycles;
  logic [1:0]  inst_bytes;
  logic [15:0] pc, pc_exp, bkpt_addr;
  logic [21:0] e;
  logic [21:0] exp_q [$];
  int          err_total, cmp_count, cyc, acc;
  // opcode, bytes, clocks when not taken, conditional
  logic [19:0] tab [26] = '{20'h00110, 20'ha5110, 20'h84180, 20'ha4140, 20'h28110,
    20'h25220, 20'h26120, 20'h24220, 20'h35220, 20'h96120, 20'h53330, 20'h42220, 20'he4110,
    20'hd4110, 20'hc4110, 20'h85330, 20'h75330, 20'he6120, 20'he8110, 20'h60221, 20'hb6341,
    20'h83130, 20'hf0130, 20'he0130, 20'h80230, 20'h93130};
  ict_core u_ict_core (.clk(clk), .nrst(nrst), .op_valid(op_valid), .opcode(opcode),
    .cond_taken(cond_taken), .rel_offset(rel_offset), .pc_load(1'b0), .pc_load_addr(16'h0000),
    .flash_wr_en(flash_wr_en), .flash_erase_en(flash_erase_en), .dbg_halt_req(dbg_halt_req),
    .dbg_run_req(dbg_run_req), .dbg_step_req(dbg_step_req), .bkpt_en(bkpt_en),
    .bkpt_addr(bkpt_addr), .op_ready(op_ready), .retire(retire), .inst_cycles(inst_cycles),
    .inst_bytes(inst_bytes), .pc(pc), .halted(halted), .code_byte_move(),
    .external_data_move(), .flash_write(), .flash_erase());
  ict_fetch_model u_ict_fetch_model (.clk(clk), .op_ready(op_ready), .op_valid(op_valid),
    .opcode(opcode), .cond_taken(cond_taken), .rel_offset(rel_offset), .stuck(stuck));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] expv);
    cmp_count++;
    if (seen !== expv)
      begin
        err_total++;
        $display("ERROR %0t seen %h expected %h", $time, seen, expv);
      end
  endtask : check
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic run_op(input logic [19:0] t);
    logic       c;
    logic [7:0] r;
    c = 1'($urandom);
    r = 8'($urandom);
    pc_exp = pc_exp + {14'h0, t[9:8]};
    if ((t[0] && c) || t[19:12] == 8'h80)
      pc_exp = pc_exp + {{8{r[7]}}, r};
    exp_q.push_back({t[7:4] + {3'h0, t[0] && c}, t[9:8], pc_exp});
    flash_wr_en <= 1'($urandom);
    flash_erase_en <= 1'($urandom);
    u_ict_fetch_model.offer(t[19:12], c, r);
  endtask : run_op
  // the retire edge is compared before the accept edge so back-to-back ops pair up
  always @(posedge clk)
  begin
    cyc++;
    if (nrst && retire)
      begin
        e = exp_q.size() > 0 ? exp_q.pop_front() : 22'h3fffff;
        check({12'h0, inst_cycles}, {12'h0, e[21:18]});
        check(16'(cyc - acc), {12'h0, e[21:18]});
        check({14'h0, inst_bytes}, {14'h0, e[17:16]});
        check(pc, e[15:0]);
      end
    if (op_valid && op_ready)
      acc = cyc;
    if (stuck)
      begin
        err_total++;
        end_sim();
      end
  end
  initial
  begin
    {nrst, flash_wr_en, flash_erase_en, dbg_halt_req, dbg_run_req, dbg_step_req} = 6'h00;
    bkpt_en = 1'b0;
    bkpt_addr = 16'h0000;
    {pc_exp, err_total, cmp_count, cyc, acc} = '0;
    void'($urandom(74474));
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    repeat (3)
      foreach (tab[i])
        run_op(tab[i]);
    u_ict_fetch_model.idle();
    dbg_halt_req <= 1'b1;
    repeat (2) @(posedge clk);
    dbg_halt_req <= 1'b0;
    dbg_step_req <= 1'b1;
    @(posedge clk);
    dbg_step_req <= 1'b0;
    check({15'h0, halted}, 16'h0001);
    run_op(tab[2]);
    u_ict_fetch_model.idle();
    dbg_run_req <= 1'b1;
    @(posedge clk);
    dbg_run_req <= 1'b0;
    repeat (40)
      run_op(tab[$urandom_range(0, 25)]);
    u_ict_fetch_model.idle();
    repeat (12) @(posedge clk);
    check({15'h0, halted}, 16'h0000);
    // breakpoint just past a multiply: it must wait for the pipe to drain, then stop issue
    bkpt_addr <= pc_exp + 16'h0001;
    bkpt_en <= 1'b1;
    run_op(tab[3]);
    u_ict_fetch_model.idle();
    repeat (5) @(posedge clk);
    check({15'h0, halted}, 16'h0001);
    bkpt_en <= 1'b0;
    dbg_run_req <= 1'b1;
    @(posedge clk);
    dbg_run_req <= 1'b0;
    run_op(tab[0]);
    u_ict_fetch_model.idle();
    repeat (4) @(posedge clk);
    check({15'h0, halted}, 16'h0000);
    check(16'(exp_q.size()), 16'h0000);
    end_sim();
  end
endmodule : ict_core_bench
